// file: design/lfsa_fault_alert.sv
/*
  fault status, report enable, alert and hiccup / latch-off response for a
  two-channel led buck driver. the register side lives on the serial
  engine's link clock and reaches this logic through toggle handshakes.
  assumes comparator flags and pins are asynchronous to i_clk; command code
  and data are latched when taken, so the serial engine need not hold them.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - overvoltage stops switching and opens disconnect, sets status, raises alert
// - near regulation with sense below 10mV sets open flag and alert
// - feedback below 250mV sets short flag only after initial start-up
// - sense above 930mV sets overcurrent flag and alert in same cycle
// - short or overcurrent stops switching and opens disconnect at once
// - hiccup runs fault timer, restarts via soft-start once expired and clear
// - after hiccup restart alert stays in serial mode, drops otherwise
// - latch-off keeps channel stopped until enable pin goes low then high
// - status bits stay set until the host clears them
// - in serial mode, a latched fault raises alert only if its report enable is 1
// - status bits 0-3 channel 1, bits 4-7 channel 2, reset zero
// - report enable uses status order, resets to ones, zero disables
// - pending alert answers an inquiry with the chip address
// - serial mode holds alert until the inquiry transfer completes
// - after a completed inquiry, ignore more until a new alert event
// - a fault whose status bit is still set raises no fresh alert
// - non-serial mode alerts on overvoltage or open regardless of registers
// - non-serial mode holds alert for short or overcurrent until hiccup timer and fault end
// - configuration bit 7 chooses hiccup when 0, latch-off when 1
// - supply below 3.2V returns every register to its default
module lfsa_fault_alert #(
  parameter int FAULT_CYC = lfsa_pkg::FAULT_CYC,
  parameter int SOFT_START_CYC = lfsa_pkg::SOFT_START_CYC,
  parameter logic [6:0] CHIP_ADDR = lfsa_pkg::CHIP_ADDR_DFLT
) (
  // device clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link clock of the serial engine
  input wire logic i_link_clk,
  // asynchronous pins and comparator flags, index is channel
  input wire logic i_enable_undervoltage_pin,
  input wire logic i_internal_supply_ok,
  input wire logic i_i2c_mode,
  input wire logic [1:0] i_output_overvoltage,
  input wire logic [1:0] i_open_string_fault,
  input wire logic [1:0] i_shorted_string_fault,
  input wire logic [1:0] i_overcurrent_fault,
  // command port from the serial engine, link domain
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd_code,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  // register read-back and alert response, link domain
  output logic [7:0] o_fault_status,
  output logic [7:0] o_fault_report_enable,
  output logic [7:0] o_config,
  output logic o_ara_respond,
  output logic [6:0] o_ara_addr,
  // power stage controls, index is channel
  output logic [1:0] o_switch_en,
  output logic [1:0] o_disconnect_gate_driver,
  // open-drain alert pin
  output logic o_alert_n_o,
  output logic o_alert_n_oe
);
  localparam int TMAX = (FAULT_CYC > SOFT_START_CYC) ? FAULT_CYC : SOFT_START_CYC;
  localparam int TW = $clog2(TMAX + 1);
  localparam logic [TW-1:0] FAULT_LOAD = TW'(FAULT_CYC);
  localparam logic [TW-1:0] SS_LOAD = TW'(SOFT_START_CYC);
  localparam int NSYNC = lfsa_pkg::STAT_W + 3;

  // refuse timer counts that the down-counters cannot serve
  if (FAULT_CYC < 1 || SOFT_START_CYC < 1) begin : g_bad_counts
    $error("fault and soft-start counts must be at least one cycle");
  end

  // status index of a flag for a channel
  function automatic int flag_idx(input int ch, input int bit_pos);
    flag_idx = ch * lfsa_pkg::FLAGS_PER_CH + bit_pos;
  endfunction

  // ---------------- input synchronisers ----------------
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [7:0] flag_s;
  logic en_s;
  logic supply_s;
  logic i2c_s;

  // pack flags in status order, then enable, supply and mode
  always_comb begin
    raw_in = '0;
    for (int c = 0; c < lfsa_pkg::NUM_CH; c++) begin
      raw_in[flag_idx(c, lfsa_pkg::BIT_OV)] = i_output_overvoltage[c];
      raw_in[flag_idx(c, lfsa_pkg::BIT_OPEN)] = i_open_string_fault[c];
      raw_in[flag_idx(c, lfsa_pkg::BIT_SHORT)] = i_shorted_string_fault[c];
      raw_in[flag_idx(c, lfsa_pkg::BIT_OC)] = i_overcurrent_fault[c];
    end
    raw_in[8] = i_enable_undervoltage_pin;
    raw_in[9] = i_internal_supply_ok;
    raw_in[10] = i_i2c_mode;
  end

  // two-stage synchroniser, only stage b is read by logic
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  assign flag_s = sync_b[7:0];
  assign en_s = sync_b[8];
  assign supply_s = sync_b[9];
  assign i2c_s = sync_b[10];

  // ---------------- command handshake, link side ----------------
  logic lk_req_tgl;
  logic [1:0] lk_code;
  logic [7:0] lk_data;
  logic lk_ack_a;
  logic lk_ack_b;

  // latch a command and flip the request; busy until the ack matches
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_req_tgl <= 1'b0;
      lk_code <= 2'h0;
      lk_data <= 8'h00;
    end else if (i_cmd_valid && o_cmd_ready) begin
      lk_req_tgl <= ~lk_req_tgl;
      lk_code <= i_cmd_code;
      lk_data <= i_cmd_data;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_ack_a <= 1'b0;
      lk_ack_b <= 1'b0;
    end else begin
      lk_ack_a <= mn_ack_tgl;
      lk_ack_b <= lk_ack_a;
    end
  end

  assign o_cmd_ready = (lk_req_tgl == lk_ack_b);

  // ---------------- command handshake, device side ----------------
  logic mn_req_a;
  logic mn_req_b;
  logic mn_ack_tgl;
  logic cmd_stb;
  logic [7:0] clr_mask;
  logic ara_done;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mn_req_a <= 1'b0;
      mn_req_b <= 1'b0;
      mn_ack_tgl <= 1'b0;
    end else begin
      mn_req_a <= lk_req_tgl;
      mn_req_b <= mn_req_a;
      mn_ack_tgl <= mn_req_b;
    end
  end

  // code and data are held stable by the link side while a request is open
  assign cmd_stb = (mn_req_b != mn_ack_tgl);
  assign clr_mask = (cmd_stb && lk_code == lfsa_pkg::CMD_CLR_STATUS) ? lk_data : 8'h00;
  assign ara_done = cmd_stb && (lk_code == lfsa_pkg::CMD_ARA_DONE);

  // ---------------- registers ----------------
  logic [7:0] fault_status;
  logic [7:0] fault_report_enable;
  logic [7:0] config_reg;
  logic [7:0] set_vec;
  logic [7:0] new_evt;
  logic [1:0] startup_done;
  logic alert_pending;
  logic plain_alert;

  // flags that may set status this cycle; short waits for start-up
  always_comb begin
    set_vec = flag_s;
    for (int c = 0; c < lfsa_pkg::NUM_CH; c++) begin
      set_vec[flag_idx(c, lfsa_pkg::BIT_SHORT)] =
        flag_s[flag_idx(c, lfsa_pkg::BIT_SHORT)] && startup_done[c];
    end
  end

  // only a bit going from clear to set, and enabled, is a new event
  assign new_evt = set_vec & ~fault_status & fault_report_enable;

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_status <= lfsa_pkg::STATUS_RST;
    end else if (!supply_s) begin
      fault_status <= lfsa_pkg::STATUS_RST;
    end else begin
      fault_status <= (fault_status & ~clr_mask) | set_vec;
    end
  end

  // report enable mask and configuration writes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_report_enable <= lfsa_pkg::REPORT_EN_RST;
      config_reg <= lfsa_pkg::CONFIG_RST;
    end else if (!supply_s) begin
      fault_report_enable <= lfsa_pkg::REPORT_EN_RST;
      config_reg <= lfsa_pkg::CONFIG_RST;
    end else if (cmd_stb && lk_code == lfsa_pkg::CMD_WR_REPORT_EN) begin
      fault_report_enable <= lk_data;
    end else if (cmd_stb && lk_code == lfsa_pkg::CMD_WR_CONFIG) begin
      config_reg <= lk_data;
    end
  end

  // alert pending in serial mode: raised by new events, dropped by a done inquiry
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      alert_pending <= 1'b0;
    end else if (!supply_s) begin
      alert_pending <= 1'b0;
    end else if (|new_evt) begin
      alert_pending <= 1'b1;
    end else if (ara_done) begin
      alert_pending <= 1'b0;
    end
  end

  // ---------------- per-channel fault response ----------------
  lfsa_pkg::lfsa_ch_state_t ch_state [2];
  logic [TW-1:0] ch_timer [2];
  logic [1:0] ch_hit;
  logic [1:0] ch_hiccup;

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_ch
      // short counts only after start-up; overcurrent always
      assign ch_hit[gc] = set_vec[flag_idx(gc, lfsa_pkg::BIT_SHORT)] ||
                          flag_s[flag_idx(gc, lfsa_pkg::BIT_OC)];
      assign ch_hiccup[gc] = (ch_state[gc] == lfsa_pkg::LFSA_HICCUP);

      // off / soft-start / run / hiccup / latch-off sequencing
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          ch_state[gc] <= lfsa_pkg::LFSA_OFF;
          ch_timer[gc] <= '0;
          startup_done[gc] <= 1'b0;
        end else if (!supply_s || !en_s) begin
          ch_state[gc] <= lfsa_pkg::LFSA_OFF;
          ch_timer[gc] <= '0;
          startup_done[gc] <= 1'b0;
        end else begin
          unique case (ch_state[gc])
            lfsa_pkg::LFSA_OFF: begin
              ch_state[gc] <= lfsa_pkg::LFSA_SOFT;
              ch_timer[gc] <= SS_LOAD;
            end
            lfsa_pkg::LFSA_SOFT, lfsa_pkg::LFSA_RUN: begin
              if (ch_hit[gc]) begin
                ch_timer[gc] <= FAULT_LOAD;
                ch_state[gc] <= config_reg[lfsa_pkg::CFG_LATCH_BIT] ?
                                lfsa_pkg::LFSA_LATCH : lfsa_pkg::LFSA_HICCUP;
              end else if (ch_state[gc] == lfsa_pkg::LFSA_SOFT) begin
                if (ch_timer[gc] == '0) begin
                  ch_state[gc] <= lfsa_pkg::LFSA_RUN;
                  startup_done[gc] <= 1'b1;
                end else begin
                  ch_timer[gc] <= ch_timer[gc] - 1'b1;
                end
              end
            end
            lfsa_pkg::LFSA_HICCUP: begin
              if (ch_timer[gc] != '0) begin
                ch_timer[gc] <= ch_timer[gc] - 1'b1;
              end else if (!ch_hit[gc]) begin
                ch_state[gc] <= lfsa_pkg::LFSA_SOFT;
                ch_timer[gc] <= SS_LOAD;
              end
            end
            lfsa_pkg::LFSA_LATCH: begin
              ch_state[gc] <= lfsa_pkg::LFSA_LATCH;
            end
            default: begin
              ch_state[gc] <= lfsa_pkg::LFSA_OFF;
            end
          endcase
        end
      end

      // switching only in soft-start or run with no overvoltage, short or overcurrent; else disconnect
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          o_switch_en[gc] <= 1'b0;
          o_disconnect_gate_driver[gc] <= 1'b1;
        end else begin
          o_switch_en[gc] <= (ch_state[gc] == lfsa_pkg::LFSA_SOFT ||
                              ch_state[gc] == lfsa_pkg::LFSA_RUN) && supply_s && en_s &&
                             !flag_s[flag_idx(gc, lfsa_pkg::BIT_OV)] && !ch_hit[gc];
          o_disconnect_gate_driver[gc] <= !((ch_state[gc] == lfsa_pkg::LFSA_SOFT ||
                              ch_state[gc] == lfsa_pkg::LFSA_RUN) && supply_s && en_s &&
                             !flag_s[flag_idx(gc, lfsa_pkg::BIT_OV)] && !ch_hit[gc]);
        end
      end
    end
  endgenerate

  // ---------------- alert pin ----------------
  // without the serial port: live ov/open, plus short/oc until hiccup ends
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      plain_alert <= 1'b0;
    end else begin
      plain_alert <= (|flag_s) || (|ch_hiccup);
    end
  end

  // serial mode follows the pending flag, so it survives a hiccup restart
  assign o_alert_n_oe = i2c_s ? alert_pending : plain_alert;
  assign o_alert_n_o = 1'b0;

  // ---------------- read-back and inquiry toward the link ----------------
  logic [23:0] snap;
  logic snap_tgl;
  logic snap_ack_a;
  logic snap_ack_b;
  logic [23:0] live;
  logic lk_snap_a;
  logic lk_snap_b;
  logic lk_snap_ack;
  logic lk_pend_a;
  logic lk_pend_b;

  assign live = {config_reg, fault_report_enable, fault_status};

  // publish a new word only when the previous one was taken
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      snap <= {lfsa_pkg::CONFIG_RST, lfsa_pkg::REPORT_EN_RST, lfsa_pkg::STATUS_RST};
      snap_tgl <= 1'b0;
      snap_ack_a <= 1'b0;
      snap_ack_b <= 1'b0;
    end else begin
      snap_ack_a <= lk_snap_ack;
      snap_ack_b <= snap_ack_a;
      if (snap_ack_b == snap_tgl && snap != live) begin
        snap <= live;
        snap_tgl <= ~snap_tgl;
      end
    end
  end

  // link side captures the held word and returns the toggle
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_snap_a <= 1'b0;
      lk_snap_b <= 1'b0;
      lk_snap_ack <= 1'b0;
      o_fault_status <= lfsa_pkg::STATUS_RST;
      o_fault_report_enable <= lfsa_pkg::REPORT_EN_RST;
      o_config <= lfsa_pkg::CONFIG_RST;
    end else begin
      lk_snap_a <= snap_tgl;
      lk_snap_b <= lk_snap_a;
      lk_snap_ack <= lk_snap_b;
      if (lk_snap_b != lk_snap_ack) begin
        {o_config, o_fault_report_enable, o_fault_status} <= snap;
      end
    end
  end

  // inquiry answered only while an alert is pending
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_pend_a <= 1'b0;
      lk_pend_b <= 1'b0;
      o_ara_respond <= 1'b0;
      o_ara_addr <= 7'h00;
    end else begin
      lk_pend_a <= alert_pending;
      lk_pend_b <= lk_pend_a;
      o_ara_respond <= lk_pend_b;
      o_ara_addr <= CHIP_ADDR;
    end
  end

  // ---------------- assertions, device clock ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_ara_done_quiet;
    ara_done && (new_evt == 8'h00);
  endsequence

  sequence s_oc_new_ch0;
    supply_s && flag_s[lfsa_pkg::BIT_OC] && !fault_status[lfsa_pkg::BIT_OC] &&
      fault_report_enable[lfsa_pkg::BIT_OC];
  endsequence

  AST_OV_STOPS: assert property (flag_s[lfsa_pkg::BIT_OV] |=> !o_switch_en[0] && o_disconnect_gate_driver[0]) else $error("overvoltage did not stop channel");
  AST_OPEN_SETS: assert property (supply_s && flag_s[lfsa_pkg::BIT_OPEN] |=> fault_status[lfsa_pkg::BIT_OPEN]) else $error("open flag not latched");
  AST_SHORT_BLANK: assert property (!startup_done[0] && !fault_status[lfsa_pkg::BIT_SHORT] && clr_mask == 8'h00 |=> !fault_status[lfsa_pkg::BIT_SHORT]) else $error("short latched before start-up");
  AST_OC_ALERT: assert property (s_oc_new_ch0 |=> fault_status[lfsa_pkg::BIT_OC] && alert_pending) else $error("overcurrent not reported with alert");
  AST_HICCUP_WAIT: assert property (en_s && supply_s && ch_hiccup[0] && ch_timer[0] != '0 |=> !o_switch_en[0] && ch_hiccup[0]) else $error("hiccup left early");
  AST_LATCH_HOLD: assert property (ch_state[0] == lfsa_pkg::LFSA_LATCH && en_s && supply_s |=> ch_state[0] == lfsa_pkg::LFSA_LATCH) else $error("latch-off exited without enable toggle");
  AST_STICKY: assert property (supply_s |=> ((($past(fault_status) & ~$past(clr_mask)) & ~fault_status) == 8'h00)) else $error("status bit lost without clear");
  AST_MASKED: assert property (!alert_pending && new_evt == 8'h00 |=> !alert_pending) else $error("alert raised without enabled new fault");
  AST_ARA_RELEASE: assert property ((supply_s and s_ara_done_quiet) |=> !alert_pending ##1 (!alert_pending || $past(|new_evt))) else $error("alert not released after inquiry");
  AST_NO_REPEAT: assert property (supply_s && !alert_pending && ((set_vec & ~fault_status) == 8'h00) |=> !alert_pending) else $error("repeat alert for set status");
endmodule
`default_nettype wire

// file: design/lfsa_pkg.sv
/*
  shared constants for the led fault status and alert block: status bit
  layout, register reset values, command codes, channel states and times.
  assumes a 125 MHz device clock.
*/
package lfsa_pkg;
  // channel count and status layout, four flags per channel
  localparam int NUM_CH = 2;
  localparam int FLAGS_PER_CH = 4;
  localparam int STAT_W = 8;
  localparam int BIT_OV = 0;
  localparam int BIT_OPEN = 1;
  localparam int BIT_SHORT = 2;
  localparam int BIT_OC = 3;
  // configuration bit that selects latch-off instead of hiccup
  localparam int CFG_LATCH_BIT = 7;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] REPORT_EN_RST = 8'hFF;
  localparam logic [7:0] CONFIG_RST = 8'h0C;

  // commands handed over from the serial engine
  localparam logic [1:0] CMD_WR_REPORT_EN = 2'h0;
  localparam logic [1:0] CMD_WR_CONFIG = 2'h1;
  localparam logic [1:0] CMD_CLR_STATUS = 2'h2;
  localparam logic [1:0] CMD_ARA_DONE = 2'h3;

  // timing: clock rate, fault timer and soft-start time
  localparam int CLK_MHZ = 125;
  localparam int FAULT_TIMER_US = 100;
  localparam int SOFT_START_US = 50;
  localparam int FAULT_CYC = FAULT_TIMER_US * CLK_MHZ;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;

  // chip address returned on an alert response inquiry (arbitrary value)
  localparam logic [6:0] CHIP_ADDR_DFLT = 7'h2A;

  // per channel power-stage state
  typedef enum logic [2:0] {
    LFSA_OFF = 3'b000,
    LFSA_SOFT = 3'b001,
    LFSA_RUN = 3'b010,
    LFSA_HICCUP = 3'b011,
    LFSA_LATCH = 3'b100
  } lfsa_ch_state_t;
endpackage

// file: tb/lfsa_fault_alert_test.sv
/*
  self-checking bench for the fault alert block: drives comparator flags and
  pins, commands through the host model, and checks pins and read-backs.
  assumes shortened fault timer and soft-start parameters.
*/
`timescale 1ns/100ps
`default_nettype none

module lfsa_fault_alert_test;
  localparam int FC = 20;
  localparam int SC = 10;
  localparam logic [6:0] ADDR = 7'h55;  // arbitrary chip address
  logic clk = 1'b0;
  logic lclk, rstn, en_pin, sup_ok, i2c, cvalid, crdy, ara, al_o, al_oe, alert_n;
  logic [1:0] ov, opn, sht, oc, ccode, sw, gate;
  logic [7:0] cdata, st, ren, cfg;
  logic [6:0] ara_addr;
  int failures = 0;
  int tests_run = 0;

  // clocks: device 8 ns, link 6 ns with an odd phase
  always #4 clk = ~clk;
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  // alert line with its pull-up
  assign alert_n = (al_oe === 1'b1) ? al_o : 1'b1;

  lfsa_fault_alert #(.FAULT_CYC(FC), .SOFT_START_CYC(SC), .CHIP_ADDR(ADDR)) u_lfsa_fault_alert (
    .i_clk(clk), .i_rstn(rstn), .i_link_clk(lclk),
    .i_enable_undervoltage_pin(en_pin), .i_internal_supply_ok(sup_ok), .i_i2c_mode(i2c),
    .i_output_overvoltage(ov), .i_open_string_fault(opn),
    .i_shorted_string_fault(sht), .i_overcurrent_fault(oc),
    .i_cmd_valid(cvalid), .i_cmd_code(ccode), .i_cmd_data(cdata), .o_cmd_ready(crdy),
    .o_fault_status(st), .o_fault_report_enable(ren), .o_config(cfg),
    .o_ara_respond(ara), .o_ara_addr(ara_addr),
    .o_switch_en(sw), .o_disconnect_gate_driver(gate),
    .o_alert_n_o(al_o), .o_alert_n_oe(al_oe));

  lfsa_host_model u_lfsa_host_model (
    .i_link_clk(lclk), .i_rstn(rstn), .i_cmd_ready(crdy), .i_fault_status(st),
    .o_cmd_valid(cvalid), .o_cmd_code(ccode), .o_cmd_data(cdata));

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  // pin snapshot: alert, switch enables, disconnect gates
  function automatic logic [7:0] pins();
    return {3'h0, alert_n, sw, gate};
  endfunction
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [1:0] code, input logic [7:0] data);
    bit ok;
    u_lfsa_host_model.send(code, data, ok);
    chk({7'h00, ok}, 8'h01, "command taken");
    wclk(1);
  endtask
  task automatic clr(input logic [7:0] exp);
    logic [7:0] v;
    bit ok;
    u_lfsa_host_model.read_clear(v, ok);
    chk(v, exp, "status before clear");
    chk(st, 8'h00, "status after clear");
    wclk(1);
  endtask
  task automatic done_test(input string name);
    $display("test %s done, mismatches so far %0d", name, failures);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #40000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial begin
    {rstn, en_pin, sup_ok, i2c} = 4'b0111;
    {ov, opn, sht, oc} = 8'h00;
    wclk(4);
    chk(pins(), 8'h13, "pins in reset");
    chk(st, 8'h00, "status reset");
    chk(ren, 8'hFF, "enable reset");
    chk(cfg, 8'h0C, "config reset");
    rstn = 1'b1;
    wclk(SC + 20);
    chk(pins(), 8'h1C, "running");
    done_test("reset");
    // overcurrent on channel 1, hiccup, inquiry, repeat without clear
    oc[0] = 1'b1;
    wclk(5);
    chk(pins(), 8'h09, "overcurrent hit");
    wclk(4);
    chk({ara, ara_addr}, {1'b1, ADDR}, "inquiry answer");
    oc[0] = 1'b0;
    wclk(FC + SC + 15);
    chk(pins(), 8'h0C, "hiccup restart");
    chk(st, 8'h08, "status latched");
    cmd(2'h3, 8'h00);
    chk(pins(), 8'h1C, "alert released");
    chk({7'h00, ara}, 8'h00, "inquiry ignored");
    oc[0] = 1'b1;
    wclk(5);
    chk(pins(), 8'h19, "no repeat alert");
    oc[0] = 1'b0;
    wclk(FC + SC + 15);
    clr(8'h08);
    done_test("hiccup");
    // masked open string, then channel 2 overvoltage
    cmd(2'h0, 8'hFD);
    chk(ren, 8'hFD, "enable written");
    opn[0] = 1'b1;
    wclk(8);
    chk(pins(), 8'h1C, "masked fault");
    chk(st, 8'h02, "open status");
    ov[1] = 1'b1;
    wclk(8);
    chk(pins(), 8'h06, "overvoltage");
    chk(st, 8'h12, "overvoltage status");
    {ov, opn} = 4'h0;
    wclk(6);
    chk(pins(), 8'h0C, "overvoltage gone");
    cmd(2'h3, 8'h00);
    clr(8'h12);
    cmd(2'h0, 8'hFF);
    done_test("mask");
    // latch-off on a channel 2 short
    cmd(2'h1, 8'h8C);
    chk(cfg, 8'h8C, "config written");
    sht[1] = 1'b1;
    wclk(5);
    chk(pins(), 8'h06, "short hit");
    sht[1] = 1'b0;
    wclk(FC + SC + 20);
    chk(pins(), 8'h06, "stays latched");
    en_pin = 1'b0;
    wclk(5);
    en_pin = 1'b1;
    sht[1] = 1'b1;
    wclk(8);
    chk(pins(), 8'h0C, "short ignored in start-up");
    sht[1] = 1'b0;
    wclk(SC + 20);
    chk(pins(), 8'h0C, "enable toggled");
    chk(st, 8'h40, "short status");
    cmd(2'h3, 8'h00);
    clr(8'h40);
    cmd(2'h1, 8'h0C);
    done_test("latch");
    // non-serial mode ignores the registers
    cmd(2'h0, 8'h00);
    i2c = 1'b0;
    wclk(3);
    opn[0] = 1'b1;
    wclk(6);
    chk(pins(), 8'h0C, "open alerts");
    opn[0] = 1'b0;
    wclk(6);
    chk(pins(), 8'h1C, "open gone");
    oc[1] = 1'b1;
    wclk(6);
    chk(pins(), 8'h06, "overcurrent ch2");
    oc[1] = 1'b0;
    wclk(8);
    chk(pins(), 8'h06, "held for timer");
    wclk(FC + SC + 15);
    chk(pins(), 8'h1C, "released after restart");
    done_test("non-serial");
    // supply dip returns registers to defaults
    i2c = 1'b1;
    sup_ok = 1'b0;
    wclk(4);
    sup_ok = 1'b1;
    wclk(8);
    chk(ren, 8'hFF, "enable default");
    chk(cfg, 8'h0C, "config default");
    chk(st, 8'h00, "status default");
    done_test("supply");
    results();
  end
endmodule

`default_nettype wire

// file: tb/lfsa_host_model.sv
/*
  serial host model for the fault alert block: issues commands on the link
  clock and reads the status copy back before clearing it.
  assumes the block takes a command at a link edge with ready high.
*/
`timescale 1ns/100ps
`default_nettype none

module lfsa_host_model (
  // link clock and reset
  input wire logic i_link_clk,
  input wire logic i_rstn,
  // command port toward the block
  input wire logic i_cmd_ready,
  input wire logic [7:0] i_fault_status,
  output logic o_cmd_valid,
  output logic [1:0] o_cmd_code,
  output logic [7:0] o_cmd_data
);
  // idle port at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 2'h0;
    o_cmd_data = 8'h00;
  end

  // hold one command until taken, then wait for the round trip and copies
  task automatic send(input logic [1:0] code, input logic [7:0] data, output bit ok);
    int n;
    ok = 1'b0;
    // no request while the block is held in reset
    while (i_rstn !== 1'b1) begin
      @(posedge i_link_clk);
    end
    @(posedge i_link_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_data = data;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge i_link_clk);
      ok = (i_cmd_ready === 1'b1);
    end
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_code = ~code;  // released lines do not keep their value
    o_cmd_data = ~data;
    for (n = 0; n < 40; n++) begin
      @(posedge i_link_clk);
      if (i_cmd_ready === 1'b1) begin
        break;
      end
    end
    repeat (8) @(posedge i_link_clk);
  endtask

  // read the status copy, then clear exactly the bits seen
  task automatic read_clear(output logic [7:0] seen, output bit ok);
    @(posedge i_link_clk);
    #1;
    seen = i_fault_status;
    send(2'h2, seen, ok);
  endtask
endmodule

`default_nettype wire
